// *** hdl/ouv_fault_response.sv ***
/*
 Output undervoltage fault response controller with an Avalon-MM register
 slave, sticky event status, masked level interrupt and output-disable.
 Assumes uv_fault comes from an asynchronous comparator and that the bus
 master follows the Avalon-MM waitrequest handshake.
*/
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module ouv_fault_response #(
   parameter int unsigned CYCLES_PER_MS = ouv_pkg::CYCLES_PER_MS
) (
   input wire logic clock, // System clock, 10 MHz
   input wire logic rst, // Synchronous reset, active high
   input wire logic [ouv_pkg::ADDR_W-1:0] avs_address, // Byte address
   input wire logic avs_read, // Read request
   input wire logic avs_write, // Write request
   input wire logic [31:0] avs_writedata, // Write data
   input wire logic [3:0] avs_byteenable, // Byte lanes
   output logic [31:0] avs_readdata, // Read data
   output logic avs_waitrequest, // Stall, low for one cycle to answer
   input wire logic uv_fault, // Undervoltage fault detect, async
   output logic output_disable, // Output-disable command
   output logic irq // Level interrupt
);

   logic fault_meta_reg;
   logic fault_sync_reg;
   logic fault_prev_reg;
   ouv_pkg::ouv_cfg_t cfg_reg;
   logic [ouv_pkg::EV_W-1:0] status_reg;
   logic [ouv_pkg::EV_W-1:0] status_next;
   logic [ouv_pkg::EV_W-1:0] mask_reg;
   logic [ouv_pkg::EV_W-1:0] events;
   logic [ouv_pkg::EV_W-1:0] status_clr;
   ouv_pkg::ouv_state_t state_reg;
   ouv_pkg::ouv_state_t state_next;
   logic [31:0] cnt_reg;
   logic [31:0] cnt_next;
   logic [2:0] retries_reg;
   logic [2:0] retries_next;
   logic wait_reg;
   logic [31:0] readdata_reg;
   logic disable_reg;
   logic irq_reg;
   logic accept;
   logic [7:0] reg_idx;
   logic [31:0] read_mux;
   logic [31:0] load1;
   logic [31:0] load2;
   logic ev_shut;
   logic ev_restart;
   logic ev_latch;

   // Down-counter load value for a delay given in ms
   function automatic logic [31:0] ms_to_load(input int unsigned ms);
      return 32'(ms * CYCLES_PER_MS - 1);
   endfunction

   // True while a state keeps the output disabled
   function automatic logic is_off(input ouv_pkg::ouv_state_t s);
      return (s == ouv_pkg::ST_OFF_WAIT) || (s == ouv_pkg::ST_LATCHED) || (s == ouv_pkg::ST_HOLD);
   endfunction

   // Two-flop synchroniser plus an edge-detect flop; the first stage feeds no logic
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         fault_meta_reg <= 1'b0;
         fault_sync_reg <= 1'b0;
         fault_prev_reg <= 1'b0;
      end
      else
      begin
         fault_meta_reg <= uv_fault;
         fault_sync_reg <= fault_meta_reg;
         fault_prev_reg <= fault_sync_reg;
      end
   end

   // Bus slave: one wait cycle, then answer with waitrequest low
   assign reg_idx = avs_address[ouv_pkg::ADDR_W-1:2];
   assign accept = (avs_read || avs_write) && !wait_reg;

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         wait_reg <= 1'b1;
      end
      else if ((avs_read || avs_write) && wait_reg)
      begin
         wait_reg <= 1'b0;
      end
      else
      begin
         wait_reg <= 1'b1;
      end
   end

   always_comb
   begin
      read_mux = 32'h0000_0000;
      unique case (reg_idx)
         ouv_pkg::CFG_IDX: read_mux[7:0] = cfg_reg;
         ouv_pkg::STAT_IDX: read_mux[ouv_pkg::EV_W-1:0] = status_reg;
         ouv_pkg::MASK_IDX: read_mux[ouv_pkg::EV_W-1:0] = mask_reg;
         ouv_pkg::STATE_IDX: read_mux[6:0] = {disable_reg, retries_reg, state_reg};
         default: read_mux = 32'h0000_0000;
      endcase
   end

   // Read data is captured in the wait cycle and stands at the answer edge
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         readdata_reg <= 32'h0000_0000;
      end
      else if (avs_read && wait_reg)
      begin
         readdata_reg <= read_mux;
      end
   end

   // Configuration and mask take writes only at the answer edge
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         cfg_reg <= ouv_pkg::CFG_RESET;
         mask_reg <= ouv_pkg::MASK_RESET;
      end
      else if (accept && avs_write && avs_byteenable[0])
      begin
         if (reg_idx == ouv_pkg::CFG_IDX)
         begin
            cfg_reg <= avs_writedata[7:0];
         end
         if (reg_idx == ouv_pkg::MASK_IDX)
         begin
            mask_reg <= avs_writedata[ouv_pkg::EV_W-1:0];
         end
      end
   end

   // Sticky status cleared by reading it; a new event wins over the clear
   assign load1 = ms_to_load(ouv_pkg::DELAY1_MS[cfg_reg.delay]);
   assign load2 = ms_to_load(ouv_pkg::DELAY2_MS[cfg_reg.delay]);
   // Only bits already captured into the read data are cleared, so an event landing in the wait cycle survives
   assign status_clr = (accept && avs_read && reg_idx == ouv_pkg::STAT_IDX) ? readdata_reg[ouv_pkg::EV_W-1:0] : '0;

   always_comb
   begin
      events = '0;
      events[ouv_pkg::EV_FAULT] = fault_sync_reg && !fault_prev_reg;
      events[ouv_pkg::EV_SHUTDOWN] = ev_shut;
      events[ouv_pkg::EV_RESTART] = ev_restart;
      events[ouv_pkg::EV_LATCH] = ev_latch;
      status_next = (status_reg & ~status_clr) | events;
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         status_reg <= '0;
         irq_reg <= 1'b0;
      end
      else
      begin
         status_reg <= status_next;
         irq_reg <= |(status_next & mask_reg);
      end
   end

   // Fault response sequencer
   always_comb
   begin
      state_next = state_reg;
      cnt_next = (cnt_reg == 32'h0000_0000) ? 32'h0000_0000 : cnt_reg - 32'h0000_0001;
      retries_next = retries_reg;
      ev_shut = 1'b0;
      ev_restart = 1'b0;
      ev_latch = 1'b0;
      unique case (state_reg)
         ouv_pkg::ST_RUN:
         begin
            if (fault_sync_reg)
            begin
               unique case (cfg_reg.response)
                  ouv_pkg::RESP_IGNORE:
                  begin
                     state_next = ouv_pkg::ST_RUN;
                  end
                  ouv_pkg::RESP_RIDE:
                  begin
                     state_next = ouv_pkg::ST_RIDE;
                     cnt_next = load1;
                  end
                  ouv_pkg::RESP_RETRY:
                  begin
                     state_next = ouv_pkg::ST_OFF_WAIT;
                     cnt_next = load2;
                     retries_next = cfg_reg.retries;
                     ev_shut = 1'b1;
                  end
                  ouv_pkg::RESP_HOLD:
                  begin
                     state_next = ouv_pkg::ST_HOLD;
                     ev_shut = 1'b1;
                  end
               endcase
            end
         end
         ouv_pkg::ST_RIDE:
         begin
            if (!fault_sync_reg)
            begin
               state_next = ouv_pkg::ST_RUN;
            end
            else if (cnt_reg == 32'h0000_0000)
            begin
               state_next = ouv_pkg::ST_OFF_WAIT;
               cnt_next = load2;
               retries_next = cfg_reg.retries;
               ev_shut = 1'b1;
            end
         end
         ouv_pkg::ST_OFF_WAIT:
         begin
            if (cnt_reg == 32'h0000_0000)
            begin
               if (retries_reg == 3'h0)
               begin
                  state_next = ouv_pkg::ST_LATCHED;
                  ev_latch = 1'b1;
               end
               else
               begin
                  state_next = ouv_pkg::ST_PROBE;
                  cnt_next = load1;
                  ev_restart = 1'b1;
                  if (retries_reg != ouv_pkg::RETRY_INF)
                  begin
                     retries_next = retries_reg - 3'h1;
                  end
               end
            end
         end
         ouv_pkg::ST_PROBE:
         begin
            // Output is back on; the fault is judged only after the soft-start window
            if (cnt_reg == 32'h0000_0000)
            begin
               if (fault_sync_reg)
               begin
                  state_next = ouv_pkg::ST_OFF_WAIT;
                  cnt_next = load2;
                  ev_shut = 1'b1;
               end
               else
               begin
                  state_next = ouv_pkg::ST_RUN;
               end
            end
         end
         ouv_pkg::ST_LATCHED, ouv_pkg::ST_HOLD:
         begin
            if (!fault_sync_reg)
            begin
               state_next = ouv_pkg::ST_RUN;
            end
         end
         default:
         begin
            state_next = ouv_pkg::ST_RUN;
         end
      endcase
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         state_reg <= ouv_pkg::ST_RUN;
         cnt_reg <= 32'h0000_0000;
         retries_reg <= 3'h0;
         disable_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         retries_reg <= retries_next;
         disable_reg <= is_off(state_next);
      end
   end

   assign avs_waitrequest = wait_reg;
   assign avs_readdata = readdata_reg;
   assign output_disable = disable_reg;
   assign irq = irq_reg;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   a_ignore_stays_on: assert property (
      (state_reg == ouv_pkg::ST_RUN && cfg_reg.response == ouv_pkg::RESP_IGNORE)
      |=> (state_reg == ouv_pkg::ST_RUN && !output_disable))
      else $error("ignore response left the run state");

   a_ride_keeps_output: assert property (
      (state_reg == ouv_pkg::ST_RIDE && fault_sync_reg && cnt_reg != 32'h0000_0000)
      |=> !output_disable)
      else $error("output disabled during ride-through");

   a_ride_then_off: assert property (
      (state_reg == ouv_pkg::ST_RIDE && fault_sync_reg && cnt_reg == 32'h0000_0000)
      |=> (state_reg == ouv_pkg::ST_OFF_WAIT && output_disable))
      else $error("no shutdown after ride-through");

   a_retry_immediate_off: assert property (
      (state_reg == ouv_pkg::ST_RUN && fault_sync_reg && cfg_reg.response == ouv_pkg::RESP_RETRY)
      |=> (output_disable && retries_reg == $past(cfg_reg.retries)))
      else $error("retry response did not disable at once");

   a_hold_until_clear: assert property (
      (state_reg == ouv_pkg::ST_HOLD && fault_sync_reg) |=> (state_reg == ouv_pkg::ST_HOLD && output_disable))
      else $error("hold state released while fault present");

   a_hold_release: assert property (
      (is_off(state_reg) && state_reg != ouv_pkg::ST_OFF_WAIT && !fault_sync_reg)
      |=> (state_reg == ouv_pkg::ST_RUN && !output_disable))
      else $error("output not restored after fault cleared");

   a_retry_count_down: assert property (
      (state_reg == ouv_pkg::ST_OFF_WAIT && cnt_reg == 32'h0000_0000 && retries_reg != 3'h0
       && retries_reg != ouv_pkg::RETRY_INF)
      |=> (state_reg == ouv_pkg::ST_PROBE && retries_reg == $past(retries_reg) - 3'h1))
      else $error("retry count not decremented on restart");

   a_exhaust_latch: assert property (
      (state_reg == ouv_pkg::ST_OFF_WAIT && cnt_reg == 32'h0000_0000 && retries_reg == 3'h0)
      |=> (state_reg == ouv_pkg::ST_LATCHED && output_disable))
      else $error("exhausted retries did not latch off");

   a_reset_clears: assert property (@(posedge clock) disable iff (1'b0)
      rst |=> (state_reg == ouv_pkg::ST_RUN && !output_disable))
      else $error("reset did not clear the fault state");

   a_restart_spacing: assert property (
      (state_next == ouv_pkg::ST_OFF_WAIT && state_reg != ouv_pkg::ST_OFF_WAIT)
      |=> (cnt_reg == $past(load2)))
      else $error("retry interval not loaded");

   a_delay1_load: assert property (
      (state_reg == ouv_pkg::ST_RUN && state_next == ouv_pkg::ST_RIDE)
      |=> (cnt_reg == ms_to_load(ouv_pkg::DELAY1_MS[$past(cfg_reg.delay)])))
      else $error("ride-through delay not loaded");

   a_infinite_retry: assert property (
      (state_reg == ouv_pkg::ST_OFF_WAIT && cnt_reg == 32'h0000_0000 && retries_reg == ouv_pkg::RETRY_INF)
      |=> (state_reg == ouv_pkg::ST_PROBE && retries_reg == ouv_pkg::RETRY_INF))
      else $error("unlimited retries ran out");

   c_ride_shutdown: cover property (state_reg == ouv_pkg::ST_RIDE ##1 state_reg == ouv_pkg::ST_OFF_WAIT);
   c_restart_recovers: cover property (state_reg == ouv_pkg::ST_PROBE ##1 state_reg == ouv_pkg::ST_RUN);
   c_latched_off: cover property (state_reg == ouv_pkg::ST_LATCHED);
   c_irq_raised: cover property (!irq ##1 irq);

endmodule

`default_nettype wire

// *** hdl/ouv_pkg.sv ***
/*
 Package for the output undervoltage fault response block: register
 indices, field layout, reset values, event bits, states and timing tables.
 Assumes a 10 MHz system clock; all other files use these names with the
 package prefix and import nothing.
*/
`default_nettype none

package ouv_pkg;

   // Clock rate and the derived cycles per millisecond
   localparam int unsigned CLOCK_HZ = 10_000_000;
   localparam int unsigned CYCLES_PER_MS = CLOCK_HZ / 1000;

   // Register indices; the byte address is four times the index
   localparam logic [7:0] CFG_IDX = 8'h45;
   localparam logic [7:0] STAT_IDX = 8'h46;
   localparam logic [7:0] MASK_IDX = 8'h47;
   localparam logic [7:0] STATE_IDX = 8'h48;
   localparam int unsigned ADDR_W = 10;

   // Reset values
   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam logic [3:0] MASK_RESET = 4'h0;

   // Status and mask bit positions
   localparam int unsigned EV_FAULT = 0;
   localparam int unsigned EV_SHUTDOWN = 1;
   localparam int unsigned EV_RESTART = 2;
   localparam int unsigned EV_LATCH = 3;
   localparam int unsigned EV_W = 4;

   // Retry code that never runs out
   localparam logic [2:0] RETRY_INF = 3'h7;

   typedef enum logic [1:0] {
      RESP_IGNORE = 2'b00,
      RESP_RIDE = 2'b01,
      RESP_RETRY = 2'b10,
      RESP_HOLD = 2'b11
   } ouv_resp_t;

   // Layout of the fault action register, bit 7 first
   typedef struct packed {
      ouv_resp_t response;
      logic [2:0] retries;
      logic [2:0] delay;
   } ouv_cfg_t;

   typedef enum logic [2:0] {
      ST_RUN = 3'b000,
      ST_RIDE = 3'b001,
      ST_OFF_WAIT = 3'b010,
      ST_PROBE = 3'b011,
      ST_LATCHED = 3'b100,
      ST_HOLD = 3'b101
   } ouv_state_t;

   // Delay times in ms, indexed by the delay code
   localparam int unsigned DELAY1_MS [8] = '{10, 20, 40, 80, 160, 320, 640, 1280};
   localparam int unsigned DELAY2_MS [8] = '{252, 558, 924, 1260, 1596, 1932, 2268, 2604};

endpackage

`default_nettype wire

// *** testbench/ouv_host.sv ***
/*
 Bus master model standing in for host software on the register bus.
 Assumes the slave answers by dropping waitrequest; the bench calls access.
*/
`timescale 1ns/1ps
`default_nettype none

module ouv_host (
   input wire logic clock, // System clock
   output logic [ouv_pkg::ADDR_W-1:0] avs_address, // Byte address
   output logic avs_read, // Read request
   output logic avs_write, // Write request
   output logic [31:0] avs_writedata, // Write data
   output logic [3:0] avs_byteenable, // Byte lanes
   input wire logic [31:0] avs_readdata, // Read data
   input wire logic avs_waitrequest // Stall
);
   initial
   begin
      avs_address = '0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hF;
   end

   // Request held until waitrequest is sampled low at an edge
   task automatic access(input logic wr, input logic [7:0] idx, input logic [31:0] d, output logic [31:0] q);
      @(posedge clock);
      avs_address <= {idx, 2'b00};
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      // No limit here: the bench's cycle ceiling ends a hung wait
      do
      begin
         @(posedge clock);
      end
      while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      avs_writedata <= ~d;
   endtask
endmodule

`default_nettype wire

// *** testbench/test_ouv_fault_response.sv ***
/*
 Self-checking bench for the undervoltage fault response controller.
 Assumes CYCLES_PER_MS of 2, so delay one of code 0 is 20 cycles, delay two 504.
*/
`timescale 1ns/1ps
`default_nettype none

module test_ouv_fault_response;
   logic clock;
   logic rst;
   logic uv_fault;
   logic [ouv_pkg::ADDR_W-1:0] avs_address;
   logic avs_read;
   logic avs_write;
   logic [31:0] avs_writedata;
   logic [3:0] avs_byteenable;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic output_disable;
   logic irq;
   logic [31:0] q;
   int num_errors = 0;
   int num_checks = 0;
   int cycles = 0;

   initial
   begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   ouv_host i_host (.clock(clock), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest));

   ouv_fault_response #(.CYCLES_PER_MS(2)) i_dut (.clock(clock), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .uv_fault(uv_fault), .output_disable(output_disable), .irq(irq));

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // Ceiling well above the roughly 13000 cycles the tests need; also ends a hung bus wait
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 30000)
      begin
         num_errors++;
         give_verdict();
      end
   end

   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
      num_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp, input string msg);
      chk_word({31'h0, got}, {31'h0, exp}, msg);
   endtask

   task automatic hold_od(input int n, input logic v);
      logic ok;
      ok = 1'b1;
      repeat (n)
      begin
         @(posedge clock);
         #1;
         if (output_disable !== v)
            ok = 1'b0;
      end
      chk_bit(ok, 1'b1, "output level held");
   endtask

   task automatic wait_od(input int n, input logic v);
      int k;
      k = 0;
      while (output_disable !== v && k < n)
      begin
         @(posedge clock);
         #1;
         k++;
      end
      chk_bit(output_disable, v, "output level reached");
   endtask

   task automatic set_uv(input logic v);
      @(posedge clock);
      uv_fault <= v;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      logic [31:0] x;
      i_host.access(1'b1, idx, d, x);
   endtask

   task automatic apply_reset(input int n);
      @(posedge clock);
      rst <= 1'b1;
      repeat (n) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
   endtask

   task automatic t_reset();
      i_host.access(1'b0, ouv_pkg::CFG_IDX, 32'h0, q);
      chk_word(q, {24'h0, ouv_pkg::CFG_RESET}, "config reset");
      i_host.access(1'b0, ouv_pkg::MASK_IDX, 32'h0, q);
      chk_word(q, {28'h0, ouv_pkg::MASK_RESET}, "mask reset");
      wr(8'h10, 32'hFF);
      i_host.access(1'b0, 8'h10, 32'h0, q);
      chk_word(q, 32'h0, "unmapped read");
      chk_bit(output_disable, 1'b0, "output on after reset");
      $display("test reset done");
   endtask

   task automatic t_ignore();
      wr(ouv_pkg::CFG_IDX, 32'h00);
      set_uv(1'b1);
      hold_od(60, 1'b0);
      set_uv(1'b0);
      i_host.access(1'b0, ouv_pkg::STAT_IDX, 32'h0, q);
      chk_word(q, 32'h1, "fault event only");
      $display("test ignore done");
   endtask

   task automatic t_ride();
      wr(ouv_pkg::CFG_IDX, 32'h40);
      set_uv(1'b1);
      repeat (8) @(posedge clock);
      uv_fault <= 1'b0;
      hold_od(40, 1'b0);
      set_uv(1'b1);
      hold_od(19, 1'b0);
      wait_od(8, 1'b1);
      hold_od(700, 1'b1);
      set_uv(1'b0);
      wait_od(6, 1'b0);
      $display("test ride done");
   endtask

   task automatic t_retry();
      wr(ouv_pkg::MASK_IDX, 32'h2);
      i_host.access(1'b0, ouv_pkg::STAT_IDX, 32'h0, q);
      wr(ouv_pkg::CFG_IDX, 32'h88);
      set_uv(1'b1);
      wait_od(5, 1'b1);
      @(posedge clock);
      #1;
      chk_bit(irq, 1'b1, "irq on shutdown");
      i_host.access(1'b0, ouv_pkg::STAT_IDX, 32'h0, q);
      chk_word(q & 32'h2, 32'h2, "shutdown status");
      @(posedge clock);
      #1;
      chk_bit(irq, 1'b0, "irq cleared by read");
      hold_od(488, 1'b1);
      wait_od(16, 1'b0);
      hold_od(16, 1'b0);
      wait_od(8, 1'b1);
      hold_od(600, 1'b1);
      i_host.access(1'b0, ouv_pkg::STAT_IDX, 32'h0, q);
      chk_word(q, 32'hE, "shutdown restart latch events");
      i_host.access(1'b0, ouv_pkg::STATE_IDX, 32'h0, q);
      chk_word(q, 32'h44, "latched state");
      apply_reset(2);
      chk_bit(output_disable, 1'b0, "reset clears latch");
      i_host.access(1'b0, ouv_pkg::CFG_IDX, 32'h0, q);
      chk_word(q, 32'h0, "config after reset");
      set_uv(1'b0);
      $display("test retry done");
   endtask

   task automatic t_hold();
      wr(ouv_pkg::CFG_IDX, 32'hC0);
      set_uv(1'b1);
      wait_od(5, 1'b1);
      hold_od(300, 1'b1);
      set_uv(1'b0);
      wait_od(6, 1'b0);
      $display("test hold done");
   endtask

   task automatic t_three();
      wr(ouv_pkg::CFG_IDX, 32'h98);
      set_uv(1'b1);
      wait_od(5, 1'b1);
      i_host.access(1'b0, ouv_pkg::STATE_IDX, 32'h0, q);
      chk_word(q, 32'h5A, "three retries loaded");
      // Three restart windows, then no fourth
      repeat (3)
      begin
         wait_od(510, 1'b0);
         wait_od(24, 1'b1);
      end
      hold_od(600, 1'b1);
      i_host.access(1'b0, ouv_pkg::STATE_IDX, 32'h0, q);
      chk_word(q, 32'h44, "latched after three");
      set_uv(1'b0);
      wait_od(6, 1'b0);
      $display("test three retries done");
   endtask

   task automatic t_delay4();
      wr(ouv_pkg::CFG_IDX, 32'h44);
      set_uv(1'b1);
      hold_od(318, 1'b0);
      wait_od(8, 1'b1);
      set_uv(1'b0);
      hold_od(3180, 1'b1);
      wait_od(20, 1'b0);
      $display("test delay code 4 done");
   endtask

   task automatic t_unlimited();
      wr(ouv_pkg::CFG_IDX, 32'hB8);
      set_uv(1'b1);
      wait_od(5, 1'b1);
      // More attempts than any finite code allows
      repeat (8)
      begin
         wait_od(510, 1'b0);
         wait_od(24, 1'b1);
      end
      set_uv(1'b0);
      wait_od(530, 1'b0);
      $display("test unlimited done");
   endtask

   initial
   begin
      rst = 1'b1;
      uv_fault = 1'b0;
      repeat (4) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      t_reset();
      t_ignore();
      t_ride();
      t_retry();
      t_hold();
      t_three();
      t_delay4();
      t_unlimited();
      give_verdict();
   end
endmodule

`default_nettype wire
